// File: aie_pkg.sv
`default_nettype none
package aie_pkg;
	localparam int NCH = 8;
	localparam int NHW = 5;
	localparam int NCFG = 1 + NCH + NCH + NCH / 2;
	localparam int NF = NHW + NCFG;
	localparam int IDX_W = 5;
	localparam int ADR_W = 8;

	// Byte offsets on the register bus
	localparam logic [7:0] OFS_ERR = 8'h00;
	localparam logic [7:0] OFS_OPEN = 8'h04;
	localparam logic [7:0] OFS_RANGE = 8'h08;
	localparam logic [7:0] OFS_IRQ_ST = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFS_HW_CLR = 8'h14;
	localparam logic [7:0] OFS_HW_ST = 8'h18;
	localparam logic [7:0] OFS_CFG0 = 8'h20;

	// Channel configuration word layout
	localparam int CFG_EN = 0;
	localparam int CFG_TYPE_LSB = 1;
	localparam int CFG_FILT_LSB = 5;
	localparam int CFG_FMT_LSB = 8;
	localparam logic [15:0] CFG_RST = 16'h0000;

	// Input type codes
	localparam logic [3:0] TYPE_TC = 4'h0;
	localparam logic [3:0] TYPE_V10 = 4'h1;
	localparam logic [3:0] TYPE_VOLT = 4'h2;
	localparam logic [3:0] TYPE_CUR = 4'h3;
	localparam logic [3:0] TYPE_RTD3 = 4'h4;
	localparam logic [3:0] TYPE_RTD4 = 4'h5;
	localparam logic [3:0] TYPE_RES = 4'h6;
	localparam logic [3:0] TYPE_MAX = 4'h6;
	localparam logic [2:0] FILT_MAX = 3'h5;
	localparam logic [2:0] FMT_MAX = 3'h5;

	// Fault indices, lowest index has highest priority
	localparam int F_WDOG = 0;
	localparam int F_CODE = 1;
	localparam int F_CAL = 2;
	localparam int F_ADC = 3;
	localparam int F_CLK = 4;
	localparam int F_CFG = 5;
	localparam int F_FILT0 = 6;
	localparam int F_FMT0 = 14;
	localparam int F_PAIR0 = 22;

	// Error word values, top hex digit always zero
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_WDOG = 16'h0216;
	localparam logic [15:0] ERR_CODE = 16'h0220;
	localparam logic [15:0] ERR_CAL = 16'h0221;
	localparam logic [15:0] ERR_ADC = 16'h0300;
	localparam logic [15:0] ERR_CLK = 16'h0301;
	localparam logic [15:0] ERR_CFG = 16'h0403;
	localparam logic [15:0] ERR_FILT0 = 16'h0404;
	localparam logic [15:0] ERR_FMT0 = 16'h040c;
	localparam logic [15:0] ERR_PAIR0 = 16'h0414;
	localparam int CLS_LSB = 9;
	localparam logic [2:0] CLS_NONE = 3'b000;
	localparam logic [2:0] CLS_HW = 3'b001;
	localparam logic [2:0] CLS_CFG = 3'b010;

	// Interrupt status bits
	localparam int IRQ_CODE = 0;
	localparam int IRQ_OPEN = 1;
	localparam int IRQ_RANGE = 2;
	localparam int IRQ_CHG = 3;
	localparam int NIRQ = 4;

	localparam logic OC_TEST_PHASE = 1'b0;
endpackage : aie_pkg
`default_nettype wire

// File: aie_code_sel.sv
`default_nettype none
module aie_code_sel (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [aie_pkg::NF-1:0] fault_i,
	output logic [15:0] err_word_o,
	output logic code_new_o
);
	import aie_pkg::*;

	logic [IDX_W-1:0] held_q;
	logic held_v_q;
	logic [IDX_W-1:0] held_d;
	logic held_v_d;
	logic [IDX_W-1:0] first;
	logic any;

	function automatic logic [15:0] word_of(input logic [IDX_W-1:0] idx);
		logic [15:0] w;
		w = ERR_CFG;
		if (idx == IDX_W'(F_WDOG)) begin
			w = ERR_WDOG;
		end else if (idx == IDX_W'(F_CODE)) begin
			w = ERR_CODE;
		end else if (idx == IDX_W'(F_CAL)) begin
			w = ERR_CAL;
		end else if (idx == IDX_W'(F_ADC)) begin
			w = ERR_ADC;
		end else if (idx == IDX_W'(F_CLK)) begin
			w = ERR_CLK;
		end else if (idx == IDX_W'(F_CFG)) begin
			w = ERR_CFG;
		end else if (idx < IDX_W'(F_FMT0)) begin
			w = ERR_FILT0 + 16'(idx - IDX_W'(F_FILT0));
		end else if (idx < IDX_W'(F_PAIR0)) begin
			w = ERR_FMT0 + 16'(idx - IDX_W'(F_FMT0));
		end else begin
			w = ERR_PAIR0 + 16'({idx - IDX_W'(F_PAIR0), 1'b0});
		end
		return w;
	endfunction : word_of

	always_comb begin
		first = '0;
		any = 1'b0;
		for (int i = NF - 1; i >= 0; i--) begin
			if (fault_i[i]) begin
				first = IDX_W'(i);
				any = 1'b1;
			end
		end
	end

	// Keep the code on show until its fault goes away
	always_comb begin
		held_d = held_q;
		held_v_d = held_v_q;
		if (!(held_v_q && fault_i[held_q])) begin
			held_d = first;
			held_v_d = any;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			held_q <= '0;
			held_v_q <= 1'b0;
		end else begin
			held_q <= held_d;
			held_v_q <= held_v_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			err_word_o <= ERR_NONE;
			code_new_o <= 1'b0;
		end else begin
			err_word_o <= held_v_d ? word_of(held_d) : ERR_NONE;
			code_new_o <= held_v_d && (!held_v_q || held_d != held_q);
		end
	end
endmodule : aie_code_sel
`default_nettype wire

// File: aie_error_reporter.sv
// Summary of operation
// - Error word: bits 15-12 zero, 11-9 class, 8-0 extended code.
// - Class 000 none, 001 hardware, 010 configuration.
// - With no error the whole word reads zero.
// - Hardware codes 216, 220, 221, 300, 301 by fault.
// - Invalid config raises critical error; general bad config gives 403.
// - Bad filter on channel n gives 404 plus n.
// - Bad data format on channel n gives 40C plus n.
// - Bad resistance-sensor pair gives 414, 416, 418 or 41A.
// - No open-circuit report on the plus/minus 10 V range.
// - Four-wire sensor: open only for broken excitation or return.
// - Over/under range only in range word, never in error word.
// - While inhibited, input changes keep being updated and delivered.
// - Open-circuit bits for enabled channels, tested every other scan.
// - Over/under range bits set per channel in range word.
`default_nettype none
module aie_error_reporter (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [aie_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [aie_pkg::NHW-1:0] hw_fault_i,
	input wire logic scan_done_i,
	input wire logic [aie_pkg::NCH-1:0] brk_exc_i,
	input wire logic [aie_pkg::NCH-1:0] brk_ret_i,
	input wire logic [aie_pkg::NCH-1:0] brk_other_i,
	input wire logic [aie_pkg::NCH-1:0] over_i,
	input wire logic [aie_pkg::NCH-1:0] under_i,
	input wire logic inhibit_i,
	output logic [15:0] err_word_o,
	output logic [15:0] open_word_o,
	output logic [15:0] range_word_o,
	output logic chg_o,
	output logic irq_o
);
	import aie_pkg::*;

	logic [15:0] cfg_q [NCH];
	logic [NHW-1:0] hw_q;
	logic [NIRQ-1:0] irq_st_q;
	logic [NIRQ-1:0] irq_mask_q;
	logic [NIRQ-1:0] irq_ev;
	logic inhib_s1_q;
	logic inhib_s2_q;
	logic oc_phase_q;
	logic [NCH-1:0] open_q;
	logic [NCH-1:0] over_q;
	logic [NCH-1:0] under_q;
	logic [NCH-1:0] open_d;
	logic [NCH-1:0] oc_now;
	logic [NCH-1:0] oc_ok;
	logic [NCH-1:0] en;
	logic [NCH-1:0] bad_type;
	logic [NCH-1:0] bad_filt;
	logic [NCH-1:0] bad_fmt;
	logic [NCH/2-1:0] bad_pair;
	logic [NF-1:0] fault;
	logic [15:0] err_word;
	logic code_new;
	logic oc_test;
	logic bus_req;
	logic wr;
	logic [31:0] rd_d;

	function automatic logic [3:0] type_of(input logic [15:0] c);
		return c[CFG_TYPE_LSB +: 4];
	endfunction : type_of

	function automatic logic is_res(input logic [15:0] c);
		return type_of(c) == TYPE_RTD3 || type_of(c) == TYPE_RTD4 ||
			type_of(c) == TYPE_RES;
	endfunction : is_res

	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] nw, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = nw[7:0];
		end
		if (sel[1]) begin
			r[15:8] = nw[15:8];
		end
		return r;
	endfunction : merge16

	// Word-aligned hit inside the channel configuration block
	function automatic logic cfg_hit(input logic [ADR_W-1:0] a);
		return a >= OFS_CFG0 && a < OFS_CFG0 + 8'(4 * NCH) &&
			a[1:0] == 2'b00;
	endfunction : cfg_hit

	// Register bus: one wait state, every access answered
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = bus_req && wb_we_i;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		if (wb_adr_i == OFS_ERR) begin
			rd_d = {16'h0000, err_word_o};
		end else if (wb_adr_i == OFS_OPEN) begin
			rd_d = {16'h0000, open_word_o};
		end else if (wb_adr_i == OFS_RANGE) begin
			rd_d = {16'h0000, range_word_o};
		end else if (wb_adr_i == OFS_IRQ_ST) begin
			rd_d = {28'h0000000, irq_st_q};
		end else if (wb_adr_i == OFS_IRQ_MASK) begin
			rd_d = {28'h0000000, irq_mask_q};
		end else if (wb_adr_i == OFS_HW_ST) begin
			rd_d = {23'h000000, inhib_s2_q, 3'h0, hw_q};
		end else if (cfg_hit(wb_adr_i)) begin
			rd_d = {16'h0000, cfg_q[3'(wb_adr_i[4:2])]};
		end
	end

	// Read data is captured with the access and held until the next read
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= rd_d;
		end
	end

	// Channel configuration words
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) begin
				cfg_q[i] <= CFG_RST;
			end
		end else if (wr && cfg_hit(wb_adr_i)) begin
			cfg_q[3'(wb_adr_i[4:2])] <=
				merge16(cfg_q[3'(wb_adr_i[4:2])], wb_dat_i, wb_sel_i);
		end
	end

	// Configuration checks on enabled channels
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			en[i] = cfg_q[i][CFG_EN];
			bad_type[i] = en[i] && type_of(cfg_q[i]) > TYPE_MAX;
			bad_filt[i] = en[i] &&
				cfg_q[i][CFG_FILT_LSB +: 3] > FILT_MAX;
			bad_fmt[i] = en[i] &&
				cfg_q[i][CFG_FMT_LSB +: 3] > FMT_MAX;
		end
		// A resistance input owns both channels of its pair
		for (int k = 0; k < NCH / 2; k++) begin
			bad_pair[k] = (en[2*k+1] && is_res(cfg_q[2*k+1])) ||
				(en[2*k] && is_res(cfg_q[2*k]) && en[2*k+1]);
		end
	end

	// Hardware faults are sticky; a new event beats a clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hw_q <= '0;
		end else if (wr && wb_adr_i == OFS_HW_CLR && wb_sel_i[0]) begin
			hw_q <= (hw_q & ~wb_dat_i[NHW-1:0]) | hw_fault_i;
		end else begin
			hw_q <= hw_q | hw_fault_i;
		end
	end

	// Hardware ahead of configuration in the fault order; range faults
	// are kept out of it on purpose
	assign fault = {bad_pair, bad_fmt, bad_filt, |bad_type, hw_q};

	aie_code_sel u_sel (
		.core_clk(core_clk),
		.rst(rst),
		.fault_i(fault),
		.err_word_o(err_word),
		.code_new_o(code_new)
	);

	// Error word leaves the block straight from a flip-flop
	always_ff @(posedge core_clk) begin
		if (rst) begin
			err_word_o <= ERR_NONE;
		end else begin
			err_word_o <= err_word;
		end
	end

	// Open-circuit evaluation per channel; a channel taken out of the test
	// (disabled or on the 10 V range) also loses its held bit at once
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			oc_ok[i] = en[i] && type_of(cfg_q[i]) != TYPE_V10;
			if (!oc_ok[i]) begin
				oc_now[i] = 1'b0;
			end else if (type_of(cfg_q[i]) == TYPE_RTD4) begin
				oc_now[i] = brk_exc_i[i] || brk_ret_i[i];
			end else begin
				oc_now[i] = brk_exc_i[i] || brk_ret_i[i] || brk_other_i[i];
			end
		end
	end

	assign oc_test = scan_done_i && oc_phase_q == OC_TEST_PHASE;
	assign open_d = oc_test ? oc_now : (open_q & oc_ok);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			oc_phase_q <= 1'b0;
		end else if (scan_done_i) begin
			oc_phase_q <= ~oc_phase_q;
		end
	end

	// Status words keep updating whatever the inhibit state
	always_ff @(posedge core_clk) begin
		if (rst) begin
			open_q <= '0;
			over_q <= '0;
			under_q <= '0;
		end else begin
			open_q <= open_d;
			if (scan_done_i) begin
				over_q <= over_i & en;
				under_q <= under_i & en;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			open_word_o <= 16'h0000;
			range_word_o <= 16'h0000;
			chg_o <= 1'b0;
		end else begin
			open_word_o <= {8'h00, open_q};
			range_word_o <= {over_q, under_q};
			chg_o <= {8'h00, open_q} != open_word_o ||
				{over_q, under_q} != range_word_o;
		end
	end

	// Inhibit comes from the backplane; it is only reported
	always_ff @(posedge core_clk) begin
		if (rst) begin
			inhib_s1_q <= 1'b0;
			inhib_s2_q <= 1'b0;
		end else begin
			inhib_s1_q <= inhibit_i;
			inhib_s2_q <= inhib_s1_q;
		end
	end

	// Interrupt events, sticky, write one to clear, set wins
	always_comb begin
		irq_ev = '0;
		irq_ev[IRQ_CODE] = code_new;
		irq_ev[IRQ_OPEN] = |(open_q & ~open_word_o[NCH-1:0]);
		irq_ev[IRQ_RANGE] = |({over_q, under_q} & ~range_word_o);
		irq_ev[IRQ_CHG] = chg_o;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_st_q <= '0;
		end else if (wr && wb_adr_i == OFS_IRQ_ST && wb_sel_i[0]) begin
			irq_st_q <= (irq_st_q & ~wb_dat_i[NIRQ-1:0]) | irq_ev;
		end else begin
			irq_st_q <= irq_st_q | irq_ev;
		end
	end

	// Mask uses the same bit layout as the status register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_mask_q <= '0;
		end else if (wr && wb_adr_i == OFS_IRQ_MASK && wb_sel_i[0]) begin
			irq_mask_q <= wb_dat_i[NIRQ-1:0];
		end
	end

	// Level interrupt while any unmasked status bit is set
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_st_q & irq_mask_q);
		end
	end
endmodule : aie_error_reporter
`default_nettype wire

// File: aie_checker.sv
`default_nettype none
module aie_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic scan_done_i,
	input wire logic [4:0] hw_fault_i,
	input wire logic [7:0] brk_exc_i,
	input wire logic [7:0] brk_ret_i,
	input wire logic [7:0] brk_other_i,
	input wire logic [7:0] over_i,
	input wire logic [7:0] under_i,
	input wire logic [15:0] err_word_o,
	input wire logic [15:0] open_word_o,
	input wire logic [15:0] range_word_o,
	input wire logic chg_o
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire [2:0] cls = err_word_o[11:9];
	a_top_zero: assert property (err_word_o[15:12] == 4'h0)
		else $error("top digit set");
	a_class_legal: assert property (cls inside {3'h0, 3'h1, 3'h2})
		else $error("bad class");
	a_none_zero: assert property (cls == 3'h0 |-> !(|err_word_o))
		else $error("code without class");
	a_hw_codes: assert property (cls == 3'h1 |->
		err_word_o[8:0] inside {9'h16, 9'h20, 9'h21, 9'h100, 9'h101})
		else $error("bad hw code");
	a_cfg_codes: assert property (cls == 3'h2 |->
		err_word_o[8:0] inside {[9'h3:9'h13], 9'h14, 9'h16, 9'h18, 9'h1a})
		else $error("bad cfg code");
	a_wdog_first: assert property (hw_fault_i[0] && !(|err_word_o)
		|-> ##3 err_word_o == 16'h0216) else $error("no watchdog code");
	a_open_quiet: assert property (scan_done_i &&
		!(|(brk_exc_i | brk_ret_i | brk_other_i)) |-> ##2
		(open_word_o & ~$past(open_word_o)) == 16'h0000)
		else $error("open without break");
	a_range_quiet: assert property (scan_done_i &&
		!(|(over_i | under_i)) |-> ##2 !(|range_word_o))
		else $error("range without cause");
	a_chg_after: assert property ($changed(open_word_o) ||
		$changed(range_word_o) |-> chg_o) else $error("no change pulse");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
endmodule : aie_checker
`default_nettype wire

// File: aie_wb_master.sv
`default_nettype none
module aie_wb_master (
	input wire logic core_clk,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	input wire logic [31:0] rdat,
	input wire logic ack
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{cyc, stb, we, adr, sel, dat} = '0;
	end
	// One classic cycle; held until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge core_clk);
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'h3, d};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		{cyc, stb} <= 2'b00;
		if (n >= 50) begin
			testbench.n_fail++;
			testbench.test_done();
		end
	endtask : xfer
endmodule : aie_wb_master
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import aie_pkg::*;
	logic core_clk = 0, rst = 1;
	logic cyc, stb, we, ack, scan, inh, chg, irq, c;
	logic [7:0] adr, exc, ret, oth, ov, un;
	logic [3:0] sel;
	logic [4:0] hw;
	logic [31:0] wd, rd, q, cw;
	logic [15:0] err, opn, rng, po, pr, e;
	int n_fail = 0, n_tests = 0, seed = 12583, ch;
	logic [15:0] hwc [5] = '{16'h0216, 16'h0220, 16'h0221, 16'h0300,
		16'h0301};
	logic [7:0] se [5] = '{8'h07, 8'h00, 8'h00, 8'h04, 8'h00};
	logic [7:0] sr [5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04};
	logic [7:0] so [5] = '{8'h04, 8'h00, 8'h04, 8'h00, 8'h00};
	logic [7:0] sx [5] = '{8'h05, 8'h05, 8'h00, 8'h00, 8'h04};
	always #12.5 core_clk = ~core_clk;
	aie_error_reporter aie_error_reporter_i (.core_clk, .rst,
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.hw_fault_i(hw), .scan_done_i(scan), .brk_exc_i(exc),
		.brk_ret_i(ret), .brk_other_i(oth), .over_i(ov), .under_i(un),
		.inhibit_i(inh), .err_word_o(err), .open_word_o(opn),
		.range_word_o(rng), .chg_o(chg), .irq_o(irq));
	aie_wb_master aie_wb_master_i (.core_clk, .cyc, .stb, .we, .adr,
		.sel, .dat(wd), .rdat(rd), .ack);
	task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
		n_tests++;
		if (g !== x) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic test_done;
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	task automatic wr(logic [7:0] a, logic [31:0] d);
		aie_wb_master_i.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rdc(string nm, logic [7:0] a, logic [15:0] x);
		aie_wb_master_i.xfer(1'b0, a, 32'h0, q);
		chk(nm, {16'h0, x}, q);
	endtask : rdc
	task automatic settle(int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : settle
	// Pulse hardware fault inputs for one cycle
	task automatic hw_pulse(logic [4:0] f);
		@(posedge core_clk);
		hw <= f;
		@(posedge core_clk);
		hw <= 5'h0;
		settle(4);
	endtask : hw_pulse
	initial begin
		{scan, inh, hw, exc, ret, oth, ov, un} = '0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		rdc("err", OFS_ERR, 16'h0);
		rdc("unmapped", 8'hfc, 16'h0);
		wr(OFS_IRQ_MASK, 32'hf);
		for (int i = 0; i < 5; i++) begin
			hw_pulse(5'(1 << i));
			rdc("hw code", OFS_ERR, hwc[i]);
			settle(2);
			chk("irq", 1, irq);
			wr(OFS_HW_CLR, 32'(1 << i));
			wr(OFS_IRQ_ST, 32'hf);
			settle(4);
			rdc("hw clear", OFS_ERR, 16'h0);
			chk("irq clear", 0, irq);
		end
		wr(OFS_IRQ_MASK, 32'h0);
		hw_pulse(5'h0a);
		rdc("priority", OFS_ERR, 16'h0220);
		chk("irq masked", 0, irq);
		wr(OFS_HW_CLR, 32'h2);
		settle(4);
		rdc("next code", OFS_ERR, 16'h0300);
		wr(OFS_HW_CLR, 32'h1f);
		wr(OFS_IRQ_ST, 32'hf);
		wr(OFS_IRQ_MASK, 32'hf);
		for (int k = 0; k < 4; k++) begin
			for (int n = 0; n < 8; n++) begin
				ch = (k == 3) ? (n | 1) : n;
				c = 1'($unsigned($random(seed)));
				case (k)
					0: cw = 32'h1 | 32'(6 + c) << 5;
					1: cw = 32'h1 | 32'(6 + c) << 8;
					2: cw = 32'h1 | 32'(7 + $unsigned($random(seed)) % 9) << 1;
					default: cw = 32'hd;
				endcase
				case (k)
					0: e = 16'h0404 + 16'(n);
					1: e = 16'h040c + 16'(n);
					2: e = 16'h0403;
					default: e = 16'h0414 + 16'(n & 6);
				endcase
				wr(OFS_CFG0 + 8'(4 * ch), cw);
				settle(3);
				rdc("cfg code", OFS_ERR, e);
				wr(OFS_CFG0 + 8'(4 * ch), 32'h0);
				settle(3);
			end
		end
		// Ch0 thermocouple, ch1 10 V range, ch2 four-wire sensor
		wr(OFS_CFG0, 32'h1);
		wr(OFS_CFG0 + 8'h4, 32'h3);
		wr(OFS_CFG0 + 8'h8, 32'hb);
		{po, pr} = '0;
		for (int j = 0; j < 5; j++) begin
			@(posedge core_clk);
			{exc, ret, oth, scan} <= {se[j], sr[j], so[j], 1'b1};
			// Scan 1 is a quiet corner: no breaks and no range faults
			ov <= (j == 1) ? 8'h00 : 8'($random(seed));
			un <= (j == 1) ? 8'h00 : 8'($random(seed));
			inh <= ~1'(j);
			@(posedge core_clk);
			scan <= 1'b0;
			c = 1'b0;
			repeat (4) begin
				@(negedge core_clk);
				c = c | chg;
			end
			settle(0);
			e = {ov & 8'h07, un & 8'h07};
			chk("open", {24'h0, sx[j]}, opn);
			chk("range", e, rng);
			chk("err", 0, err);
			chk("chg", ({8'h0, sx[j]} !== po) || (e !== pr), c);
			{po, pr} = {8'h0, sx[j], e};
		end
		rdc("hw st", OFS_HW_ST, 16'h0100);
		test_done();
	end
endmodule : testbench
bind aie_error_reporter aie_checker aie_checker_i (.core_clk, .rst,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .scan_done_i, .hw_fault_i,
	.brk_exc_i, .brk_ret_i, .brk_other_i, .over_i, .under_i,
	.err_word_o,
	.open_word_o, .range_word_o, .chg_o);
`default_nettype wire
